// ---- inc/cer_pkg.sv ----
// cer_pkg: constants shared by the contact event recorder.
// assumes a 50 MHz system clock; only TICK_CYCLES below derives a cycle count from it.
package cer_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 100_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = 10;
  localparam int MS_PER_SEC = 1000;
  localparam int TAG_RES_US = 1000;
  // debounce windows, in ticks, rounded up
  localparam int ACT_TIME_US = 3300;
  localparam int INACT_TIME_US = 17780;
  localparam int DBN_CNT_W = 8;
  localparam logic [DBN_CNT_W-1:0] ACT_TICKS =
    DBN_CNT_W'((ACT_TIME_US * 1000 + TICK_NS - 1) / TICK_NS);
  localparam logic [DBN_CNT_W-1:0] INACT_TICKS =
    DBN_CNT_W'((INACT_TIME_US * 1000 + TICK_NS - 1) / TICK_NS);
  // event store
  localparam int NUM_INPUTS = 4;
  localparam int EVT_DEPTH = 50;
  localparam int AGE_LIMIT_DAYS = 55;
  localparam int SEC_PER_DAY = 86400;
  localparam logic [31:0] AGE_LIMIT_SEC = 32'(AGE_LIMIT_DAYS * SEC_PER_DAY);
  localparam int REC_CH_LSB = 0;
  localparam int REC_MS_LSB = 2;
  localparam int REC_SEC_LSB = 34;
  localparam int REC_W = 66;
  // address switches
  localparam int NET_ADDR_W = 9;
  // indicator blink periods in ms
  localparam logic [9:0] SLOW_PERIOD_MS = 10'h3E8;
  localparam logic [9:0] SLOW_HALF_MS = 10'h1F4;
  localparam logic [9:0] FAST_PERIOD_MS = 10'h0FA;
  localparam logic [9:0] FAST_HALF_MS = 10'h07D;
  // register word indices
  localparam int AVS_AW = 3;
  localparam logic [AVS_AW-1:0] REG_EVT_COUNT = 3'h0;
  localparam logic [AVS_AW-1:0] REG_EVT_TIME = 3'h1;
  localparam logic [AVS_AW-1:0] REG_EVT_CHAN = 3'h2;
  localparam logic [AVS_AW-1:0] REG_EVT_POP = 3'h3;
  localparam logic [AVS_AW-1:0] REG_TIME_NOW = 3'h4;
  localparam logic [AVS_AW-1:0] REG_IRQ_STAT = 3'h5;
  localparam logic [AVS_AW-1:0] REG_IRQ_MASK = 3'h6;
  localparam logic [AVS_AW-1:0] REG_UNIT_INFO = 3'h7;
  // field positions
  localparam int CHAN_VALID_BIT = 8;
  localparam int POP_BIT = 0;
  localparam int INFO_LVL_LSB = 16;
  localparam int IRQ_W = 3;
  localparam int IRQ_NEW = 0;
  localparam int IRQ_OVW = 1;
  localparam int IRQ_AGED = 2;
endpackage

// ---- core/cer_debounce.sv ----
// cer_debounce: one contact input, synchronised, sense-corrected and qualified.
// assumes i_tick is a one-cycle pulse every 0.1 ms from the parent time base.
`timescale 1ns/10ps
module cer_debounce import cer_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_raw,
  input wire logic i_sense,
  input wire logic i_tick,
  output logic o_active,
  output logic o_rise
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic act;
    logic rise;
    logic [DBN_CNT_W-1:0] cnt;
  } cer_dbn_t;

  cer_dbn_t s_q;
  cer_dbn_t s_d;
  logic lvl;

  // next state: count ticks while level differs from accepted state
  always_comb begin
    s_d = s_q;
    s_d.sync1 = i_raw;
    s_d.sync2 = s_q.sync1;
    s_d.rise = 1'b0;
    lvl = i_sense ? s_q.sync2 : ~s_q.sync2;
    if (lvl == s_q.act) begin
      s_d.cnt = '0; // any glitch restarts the window
    end else if (i_tick) begin
      if (!s_q.act && s_q.cnt == ACT_TICKS) begin
        s_d.act = 1'b1;
        s_d.rise = 1'b1;
        s_d.cnt = '0;
      end else if (s_q.act && s_q.cnt == INACT_TICKS) begin
        s_d.act = 1'b0;
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_active = s_q.act;
  assign o_rise = s_q.rise;
endmodule // cer_debounce

// ---- core/cer_recorder.sv ----
// cer_recorder: four-input contact event recorder with time-tagged store.
// assumes contact, switch and status inputs are synchronous levels on I_CLOCK,
// and that the controller reaches the store over an Avalon-MM slave port.
//
// Overview of operation
// - four contact inputs, each sense selectable
// - time tag resolution finer than 2 ms
// - controller loads the time base; device follows
// - store holds 50; full overwrites oldest
// - records older than 55 days removed
// - records kept until the controller takes them
// - record only on inactive-to-active debounced change
// - active accepted after 3.3 ms continuous
// - inactive accepted after 17.78 ms continuous
// - four sense switch bits, one per input
// - address from two digits plus jumper as top
// - green slow flash when healthy
// - amber fast flash on hardware fault
// - red fast or steady during transmission
// - address is low + 16*high + 256*jumper removed
// - sense set: voltage applied is active
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
module cer_recorder import cer_pkg::*; #(
  parameter int DEPTH = EVT_DEPTH,
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [NUM_INPUTS-1:0] I_CONTACT,
  input wire logic [NUM_INPUTS-1:0] I_SENSE_SW,
  input wire logic [3:0] I_ADDR_LOW_DIGIT,
  input wire logic [3:0] I_ADDR_HIGH_DIGIT,
  input wire logic I_ADDR_TOP_JUMPER,
  input wire logic I_HW_FAULT,
  input wire logic I_TX_ACTIVE,
  input wire logic I_TX_BURST,
  input wire logic [AVS_AW-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  output logic O_IRQ,
  output logic O_LED_GREEN,
  output logic O_LED_AMBER,
  output logic O_LED_RED,
  output logic [NET_ADDR_W-1:0] O_NET_ADDR
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int TICK_W = $clog2(TICK_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [3:0] SUBMS_LAST = 4'(TICKS_PER_MS - 1);
  localparam logic [9:0] MS_LAST = 10'(MS_PER_SEC - 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic [3:0] sub_ms;
    logic [31:0] ms_time;
    logic [9:0] ms_frac;
    logic [31:0] sec_up;
    logic [9:0] blink_ms;
    logic [NUM_INPUTS-1:0] pend;
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] tail;
    logic [PTR_W:0] cnt;
    logic [DEPTH-1:0][REC_W-1:0] mem;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic irq;
    logic wreq;
    logic [31:0] rdata;
    logic led_g;
    logic led_a;
    logic led_r;
    logic [NET_ADDR_W-1:0] net_addr;
  } cer_state_t;

  cer_state_t s_q;
  cer_state_t s_d;

  logic tick;
  logic ms_step;
  logic [NUM_INPUTS-1:0] rise;
  logic [NUM_INPUTS-1:0] level;
  logic rd_req;
  logic wr_done;
  logic rd_take;
  logic bus_pop;
  logic aged;
  logic do_push;
  logic do_pop;
  logic full;
  logic adv_head;
  logic [1:0] push_ch;
  logic [NUM_INPUTS-1:0] served;
  logic [REC_W-1:0] head_rec;
  logic [REC_W-1:0] new_rec;
  logic [31:0] rd_mux;
  logic [IRQ_W-1:0] irq_set;
  logic slow_on;
  logic fast_on;

  // 0.1 ms tick feeds debounce and time base
  assign tick = (s_q.tick_cnt == TICK_LAST);
  assign ms_step = tick && (s_q.sub_ms == SUBMS_LAST);

  // one debouncer per contact input
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
      cer_debounce u_dbn (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_raw(I_CONTACT[gi]),
        .i_sense(I_SENSE_SW[gi]),
        .i_tick(tick),
        .o_active(level[gi]),
        .o_rise(rise[gi])
      );
    end
  endgenerate

  // bus decode: request seen while waitrequest high, completes next cycle
  assign rd_req = I_AVS_READ && s_q.wreq;
  assign wr_done = I_AVS_WRITE && !s_q.wreq;
  assign rd_take = I_AVS_READ && !s_q.wreq;
  assign bus_pop = wr_done && (I_AVS_ADDRESS == REG_EVT_POP)
    && I_AVS_WRITEDATA[POP_BIT];

  // store status and head record
  assign head_rec = s_q.mem[s_q.head];
  assign full = (s_q.cnt == CNT_FULL);
  assign aged = (s_q.cnt != '0)
    && ((s_q.sec_up - head_rec[REC_SEC_LSB +: 32]) >= AGE_LIMIT_SEC);

  // lowest pending channel is stored first; one record per cycle
  always_comb begin
    push_ch = '0;
    served = '0;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (s_q.pend[i]) begin
        push_ch = 2'(i);
      end
    end
    if (s_q.pend != '0) begin
      served[push_ch] = 1'b1;
    end
  end

  assign do_push = (s_q.pend != '0);
  assign do_pop = (bus_pop || aged) && (s_q.cnt != '0);
  assign adv_head = do_pop || (do_push && full);
  assign new_rec = {s_q.sec_up, s_q.ms_time, push_ch};

  assign irq_set[IRQ_NEW] = do_push;
  assign irq_set[IRQ_OVW] = do_push && full && !do_pop;
  assign irq_set[IRQ_AGED] = aged;

  // read data for the addressed register
  always_comb begin
    rd_mux = '0;
    unique case (I_AVS_ADDRESS)
      REG_EVT_COUNT: begin
        rd_mux[PTR_W:0] = s_q.cnt;
      end
      REG_EVT_TIME: begin
        rd_mux = head_rec[REC_MS_LSB +: 32];
      end
      REG_EVT_CHAN: begin
        rd_mux[1:0] = head_rec[REC_CH_LSB +: 2];
        rd_mux[CHAN_VALID_BIT] = (s_q.cnt != '0);
      end
      REG_EVT_POP: begin
        rd_mux = '0;
      end
      REG_TIME_NOW: begin
        rd_mux = s_q.ms_time;
      end
      REG_IRQ_STAT: begin
        rd_mux[IRQ_W-1:0] = s_q.stat;
      end
      REG_IRQ_MASK: begin
        rd_mux[IRQ_W-1:0] = s_q.mask;
      end
      REG_UNIT_INFO: begin
        rd_mux[NET_ADDR_W-1:0] = s_q.net_addr;
        rd_mux[INFO_LVL_LSB +: NUM_INPUTS] = level;
      end
    endcase
  end

  // indicator phases from a free ms counter
  assign slow_on = (s_q.blink_ms < SLOW_HALF_MS);
  assign fast_on = ((s_q.blink_ms % FAST_PERIOD_MS) < FAST_HALF_MS);

  // next state
  always_comb begin
    s_d = s_q;

    // prescaler and time counters
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
    if (tick) begin
      s_d.sub_ms = (s_q.sub_ms == SUBMS_LAST) ? '0 : s_q.sub_ms + 1'b1;
    end
    if (ms_step) begin
      s_d.ms_time = s_q.ms_time + 32'h0000_0001;
      s_d.ms_frac = (s_q.ms_frac == MS_LAST) ? '0 : s_q.ms_frac + 1'b1;
      s_d.blink_ms = (s_q.blink_ms == SLOW_PERIOD_MS - 10'h001)
        ? '0 : s_q.blink_ms + 1'b1;
      if (s_q.ms_frac == MS_LAST) begin
        s_d.sec_up = s_q.sec_up + 32'h0000_0001;
      end
    end
    // controller write realigns the tag base and its sub-ms phase
    if (wr_done && I_AVS_ADDRESS == REG_TIME_NOW) begin
      s_d.ms_time = I_AVS_WRITEDATA;
      s_d.sub_ms = '0;
      s_d.tick_cnt = '0;
    end

    // pending flags: a new rise wins over the service clear
    s_d.pend = (s_q.pend & ~served) | rise;

    // store pointers; uptime seconds never jump, so age is safe
    if (do_push) begin
      s_d.mem[s_q.tail] = new_rec;
      s_d.tail = (s_q.tail == PTR_LAST) ? '0 : s_q.tail + 1'b1;
    end
    if (adv_head) begin
      s_d.head = (s_q.head == PTR_LAST) ? '0 : s_q.head + 1'b1;
    end
    if (do_push && !adv_head) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (!do_push && adv_head) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end

    // interrupt status: write one clears, set wins
    if (wr_done && I_AVS_ADDRESS == REG_IRQ_STAT) begin
      s_d.stat = s_q.stat & ~I_AVS_WRITEDATA[IRQ_W-1:0];
    end
    s_d.stat = s_d.stat | irq_set;
    if (wr_done && I_AVS_ADDRESS == REG_IRQ_MASK) begin
      s_d.mask = I_AVS_WRITEDATA[IRQ_W-1:0];
    end
    s_d.irq = |(s_q.stat & s_q.mask);

    // slave handshake: one wait cycle, then a one-cycle acknowledge
    s_d.wreq = !((I_AVS_READ || I_AVS_WRITE) && s_q.wreq);
    if (rd_req) begin
      s_d.rdata = rd_mux;
    end else if (rd_take) begin
      s_d.rdata = s_q.rdata;
    end

    // indicator: fault first, then transmit, then healthy
    s_d.led_g = 1'b0;
    s_d.led_a = 1'b0;
    s_d.led_r = 1'b0;
    if (I_HW_FAULT) begin
      s_d.led_a = fast_on;
    end else if (I_TX_ACTIVE) begin
      s_d.led_r = I_TX_BURST ? 1'b1 : fast_on;
    end else begin
      s_d.led_g = slow_on;
    end

    // jumper fitted reads as zero in the top address bit
    s_d.net_addr = {!I_ADDR_TOP_JUMPER, I_ADDR_HIGH_DIGIT, I_ADDR_LOW_DIGIT};
  end

  // state register; waitrequest idles high
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      s_q <= '0;
      s_q.wreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // all outputs straight from the state register
  assign O_AVS_READDATA = s_q.rdata;
  assign O_AVS_WAITREQUEST = s_q.wreq;
  assign O_IRQ = s_q.irq;
  assign O_LED_GREEN = s_q.led_g;
  assign O_LED_AMBER = s_q.led_a;
  assign O_LED_RED = s_q.led_r;
  assign O_NET_ADDR = s_q.net_addr;
endmodule // cer_recorder

// ---- bench/cer_rec_assertions.sv ----
// cer_rec_assertions: bus, store and indicator checks at the recorder ports.
// assumes it is bound into cer_recorder and sees its ports only.
`timescale 1ns/10ps
module cer_rec_assertions import cer_pkg::*; #(
  parameter int DEPTH = EVT_DEPTH
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_HW_FAULT,
  input wire logic [AVS_AW-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic O_LED_GREEN,
  input wire logic O_LED_AMBER,
  input wire logic O_LED_RED,
  input wire logic [NET_ADDR_W-1:0] O_NET_ADDR
);
  logic ack;
  logic ack_rd;
  // read data only means something in the acknowledge cycle
  assign ack = !O_AVS_WAITREQUEST;
  assign ack_rd = ack && I_AVS_READ;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("acknowledge held over one cycle");
  a_req_answered: assert property ((I_AVS_READ || I_AVS_WRITE) && !ack |=> ack)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (ack |-> $past(I_AVS_READ || I_AVS_WRITE))
    else $error("acknowledge without request");
  a_info_addr: assert property (ack_rd && I_AVS_ADDRESS == REG_UNIT_INFO
    |-> O_AVS_READDATA[8:0] == O_NET_ADDR) else $error("unit info address differs");
  a_count_max: assert property (ack_rd && I_AVS_ADDRESS == REG_EVT_COUNT
    |-> O_AVS_READDATA <= 32'(DEPTH)) else $error("record count above depth");
  a_pop_zero: assert property (ack_rd && I_AVS_ADDRESS == REG_EVT_POP
    |-> O_AVS_READDATA == '0) else $error("pop register read not zero");
  a_led_onehot: assert property ($onehot0({O_LED_GREEN, O_LED_AMBER, O_LED_RED}))
    else $error("two indicator colours lit");
  a_fault_amber: assert property (I_HW_FAULT [*3] |-> !O_LED_GREEN && !O_LED_RED)
    else $error("fault shown in wrong colour");
endmodule // cer_rec_assertions

bind cer_recorder cer_rec_assertions #(.DEPTH(DEPTH)) u_cer_rec_assertions (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_HW_FAULT(I_HW_FAULT),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_LED_GREEN(O_LED_GREEN), .O_LED_AMBER(O_LED_AMBER), .O_LED_RED(O_LED_RED),
  .O_NET_ADDR(O_NET_ADDR)
);

// ---- bench/cer_ctrl_model.sv ----
// cer_ctrl_model: substation controller reading the recorder over Avalon-MM.
// assumes tasks are called from a process synchronised to i_clk.
`timescale 1ns/10ps
module cer_ctrl_model import cer_pkg::*; (
  input wire logic i_clk,
  input wire logic i_waitreq,
  input wire logic [31:0] i_rdata,
  output logic [AVS_AW-1:0] o_addr,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_wdata,
  output logic o_tmo
);
  // idle bus at time zero
  initial begin
    o_addr = '0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_wdata = '0;
    o_tmo = 1'b0;
  end
  // hold until acknowledge; no latency assumed, only a bound against hangs
  task automatic await_ack();
    int n;
    n = 0;
    @(posedge i_clk);
    while (i_waitreq !== 1'b0 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    // only a bus still stalled at the bound counts as hung
    if (i_waitreq !== 1'b0) o_tmo = 1'b1;
  endtask
  // one edge first, so back-to-back calls never drive a signal twice at once
  task automatic wr(input logic [AVS_AW-1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_write <= 1'b1;
    await_ack();
    o_write <= 1'b0;
    o_wdata <= ~d; // released data scrambled
    o_addr <= ~a;
  endtask
  // records are fetched whenever this side chooses
  task automatic rd(input logic [AVS_AW-1:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_read <= 1'b1;
    await_ack();
    d = i_rdata;
    o_read <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule // cer_ctrl_model

// ---- bench/cer_recorder_test.sv ----
// cer_recorder_test: scenario bench for the contact event recorder.
// assumes TICK_CYC 10 (1 ms = 100 cycles) and a four-deep store.
`timescale 1ns/10ps
module cer_recorder_test import cer_pkg::*;;
  localparam int MS = 100;
  logic clk, rst, jmp, fault, tx, burst, rd_s, wr_s, wreq, irq, g, a, r, tmo;
  logic [3:0] contact, sense, lo, hi;
  logic [AVS_AW-1:0] adr;
  logic [31:0] wdat, rdat, v, t0;
  logic [8:0] naddr;
  int bad_count, n_tests, ce[3], ch[3];
  // 50 MHz clock
  always #10 clk = ~clk;
  cer_recorder #(.DEPTH(4), .TICK_CYC(10)) u_cer_recorder (
    .I_CLOCK(clk), .I_RST(rst), .I_CONTACT(contact), .I_SENSE_SW(sense),
    .I_ADDR_LOW_DIGIT(lo), .I_ADDR_HIGH_DIGIT(hi), .I_ADDR_TOP_JUMPER(jmp),
    .I_HW_FAULT(fault), .I_TX_ACTIVE(tx), .I_TX_BURST(burst), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd_s), .I_AVS_WRITE(wr_s), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wreq), .O_IRQ(irq), .O_LED_GREEN(g), .O_LED_AMBER(a),
    .O_LED_RED(r), .O_NET_ADDR(naddr));
  cer_ctrl_model u_cer_ctrl_model (.i_clk(clk), .i_waitreq(wreq), .i_rdata(rdat),
    .o_addr(adr), .o_read(rd_s), .o_write(wr_s), .o_wdata(wdat), .o_tmo(tmo));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [AVS_AW-1:0] ad, input logic [31:0] d);
    u_cer_ctrl_model.wr(ad, d);
  endtask
  task automatic rd(input logic [AVS_AW-1:0] ad, input string nm, input logic [31:0] exp);
    u_cer_ctrl_model.rd(ad, v);
    check(nm, v, exp);
  endtask
  // whole ms holds keep clear of both debounce windows
  task automatic hold(input int k, input logic lvl, input int ms);
    contact[k] <= lvl;
    cyc(ms * MS);
  endtask
  task automatic t_addr();
    cyc(3);
    check("net address", 32'(naddr), 32'h19B);
    rd(REG_UNIT_INFO, "unit info", 32'h19B);
    jmp <= 1'b1;
    cyc(3);
    check("net address fitted", 32'(naddr), 32'h09B);
    $display("address test done");
  endtask
  task automatic t_debounce();
    wr(REG_IRQ_MASK, 32'h7);
    rd(REG_IRQ_MASK, "mask readback", 32'h7);
    hold(2, 1'b1, 2);
    hold(2, 1'b0, 3);
    rd(REG_EVT_COUNT, "count short pulse", 32'h0);
    hold(2, 1'b1, 5);
    rd(REG_EVT_COUNT, "count held", 32'h1);
    rd(REG_EVT_CHAN, "oldest input", 32'h102);
    check("irq raised", irq, 32'h1);
    hold(0, 1'b0, 5);
    rd(REG_EVT_CHAN, "oldest kept", 32'h102);
    rd(REG_EVT_COUNT, "count removal", 32'h2);
    rd(REG_UNIT_INFO, "active levels", 32'h0005_009B);
    wr(REG_IRQ_STAT, 32'h7);
    cyc(2);
    check("irq cleared", irq, 32'h0);
    $display("debounce test done");
  endtask
  task automatic t_rearm();
    wr(REG_IRQ_MASK, 32'h0);
    hold(2, 1'b0, 10);
    hold(2, 1'b1, 5);
    rd(REG_EVT_COUNT, "count short gap", 32'h2);
    hold(2, 1'b0, 20);
    hold(2, 1'b1, 5);
    rd(REG_EVT_COUNT, "count rearmed", 32'h3);
    check("irq masked", irq, 32'h0);
    $display("rearm test done");
  endtask
  task automatic t_store();
    hold(1, 1'b1, 5);
    hold(3, 1'b1, 5);
    rd(REG_EVT_COUNT, "count full", 32'h4);
    rd(REG_IRQ_STAT, "status overwrite", 32'h3);
    rd(REG_EVT_CHAN, "oldest after overwrite", 32'h100);
    wr(REG_EVT_POP, 32'h1);
    rd(REG_EVT_CHAN, "next oldest", 32'h102);
    rd(REG_EVT_COUNT, "count popped", 32'h3);
    rd(REG_EVT_POP, "pop reads zero", 32'h0);
    $display("store test done");
  endtask
  task automatic t_time();
    wr(REG_TIME_NOW, 32'h1000);
    cyc(550);
    rd(REG_TIME_NOW, "time base", 32'h1005);
    repeat (3) wr(REG_EVT_POP, 32'h1);
    rd(REG_EVT_CHAN, "store empty", 32'h0);
    hold(1, 1'b0, 20);
    u_cer_ctrl_model.rd(REG_TIME_NOW, t0);
    hold(1, 1'b1, 5);
    u_cer_ctrl_model.rd(REG_EVT_TIME, v);
    check("tag offset", 32'(v - t0 inside {32'h3, 32'h4}), 32'h1);
    $display("time test done");
  endtask
  // count edges and lit cycles of each colour over 130 ms
  task automatic win();
    logic [2:0] p;
    logic [2:0] c;
    ce = '{0, 0, 0};
    ch = '{0, 0, 0};
    cyc(5);
    p = {r, a, g};
    repeat (130 * MS) begin
      @(posedge clk);
      c = {r, a, g};
      for (int i = 0; i < 3; i++) begin
        ce[i] += int'(c[i] !== p[i]);
        ch[i] += int'(c[i] === 1'b1);
      end
      p = c;
    end
  endtask
  task automatic t_leds();
    win();
    check("green alone", ch[1] + ch[2], 32'h0);
    check("green slow", ce[0] <= 1, 32'h1);
    fault <= 1'b1;
    win();
    check("amber flash", ce[1] >= 1, 32'h1);
    fault <= 1'b0;
    tx <= 1'b1;
    burst <= 1'b1;
    win();
    check("red steady", ch[2], 130 * MS);
    burst <= 1'b0;
    win();
    check("red flash", ce[2] >= 1, 32'h1);
    $display("indicator test done");
  endtask
  // a bus that never answers ends the run
  always @(posedge clk) begin
    if (tmo === 1'b1) begin
      bad_count++;
      give_verdict();
    end
  end
  // input 0 senses removal, the others application of voltage
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    contact = 4'h1;
    sense = 4'hE;
    lo = 4'hB;
    hi = 4'h9;
    jmp = 1'b0;
    fault = 1'b0;
    tx = 1'b0;
    burst = 1'b0;
    bad_count = 0;
    n_tests = 0;
    cyc(6);
    rst <= 1'b0;
    cyc(2);
    t_addr();
    t_debounce();
    t_rearm();
    t_store();
    t_time();
    t_leds();
    give_verdict();
  end
endmodule // cer_recorder_test
